// File: design/dmag_pkg.sv
// ============================================================
// Shared constants of the data memory address generator
package dmag_pkg;
  // Widths of the data path, the address and the bank number, and the pointer and bank counts
  localparam int ADDR_W = 12;
  localparam int DATA_W = 8;
  localparam int BANK_W = 4;
  localparam int NUM_PTRS = 3;
  localparam int NUM_BANKS = 16;

  // Fast access region: offsets below the split go to bank zero, the rest to bank fifteen
  localparam logic [7:0] ACCESS_SPLIT = 8'h80;
  localparam logic [3:0] ACCESS_LOW_BANK = 4'h0;
  localparam logic [3:0] SFR_BANK = 4'hF;

  // Register addresses inside the special function bank
  localparam logic [11:0] BANK_SELECT_ADDR = 12'hFD0;
  localparam logic [11:0] PTR_BLK0 = 12'hFE8;
  localparam logic [11:0] PTR_BLK_STEP = 12'h008;

  // Sub-address within one pointer's block of eight locations
  localparam logic [2:0] SUB_OFFSET_IDX = 3'h0;
  localparam logic [2:0] SUB_PRE_INC = 3'h1;
  localparam logic [2:0] SUB_POST_DEC = 3'h2;
  localparam logic [2:0] SUB_POST_INC = 3'h3;
  localparam logic [2:0] SUB_PLAIN = 3'h4;
  localparam logic [2:0] SUB_HIGH = 3'h5;
  localparam logic [2:0] SUB_LOW = 3'h6;

  // Reset values and fixed read values
  localparam logic [3:0] BANK_SELECT_RST = 4'h0;
  localparam logic [11:0] PTR_RST = 12'h000;
  localparam logic [7:0] DATA_ZERO = 8'h00;
  localparam logic [3:0] UPPER_ZERO = 4'h0;
endpackage

// File: design/dmag_ptr_reg.sv
`timescale 1ns/1ps
// ============================================================
// One indirect pointer: a high and a low byte that act as one counter
module dmag_ptr_reg #(
  parameter int W = 12
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rstn,
  // Update requests
  input wire logic inc,
  input wire logic dec,
  input wire logic wr_high,
  input wire logic wr_low,
  input wire logic [7:0] wdata,
  // Pointer value
  output logic [W-1:0] ptr
);
  logic [W-1:0] next_ptr;

  // A byte write beats any pending step, so software can reload a pointer it walks
  always_comb begin
    next_ptr = ptr;
    if (wr_high || wr_low) begin
      if (wr_high) begin
        next_ptr[W-1:8] = wdata[W-9:0];
      end
      if (wr_low) begin
        next_ptr[7:0] = wdata;
      end
    end else if (inc) begin
      next_ptr = ptr + 1'b1;
    end else if (dec) begin
      next_ptr = ptr - 1'b1;
    end
  end

  // Pointer storage
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      ptr <= dmag_pkg::PTR_RST;
    end else begin
      ptr <= next_ptr;
    end
  end

  write_wins_a: assert property (@(posedge clock) disable iff (!rstn)
    wr_low && (inc || dec) |=> ptr[7:0] == $past(wdata))
    else $error("pointer step overrode a low byte write");

  carry_high_a: assert property (@(posedge clock) disable iff (!rstn)
    inc && !wr_high && !wr_low && ptr[7:0] == 8'hFF |=> ptr[W-1:8] == $past(ptr[W-1:8]) + 1'b1)
    else $error("increment did not carry into high byte");
endmodule

// File: design/dmag_core.sv
`timescale 1ns/1ps
module dmag_core #(
  parameter int BANKS_IMPL = 16
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rstn,
  // Access request from the execute stage
  input wire logic req,
  input wire logic req_write,
  input wire logic [7:0] file_offset,
  input wire logic access_sel,
  input wire logic full_move,
  input wire logic [11:0] full_addr,
  input wire logic [7:0] wdata,
  input wire logic [7:0] working_reg,
  // Bank literal load
  input wire logic bank_literal_load,
  input wire logic [7:0] bank_literal,
  // Data RAM
  input wire logic [7:0] ram_rdata,
  output logic [11:0] ram_addr,
  output logic ram_rd,
  output logic ram_wr,
  output logic [7:0] ram_wdata,
  // Answer to the execute stage
  output logic done,
  output logic [7:0] rd_data,
  output logic zero_force,
  output logic flags_hold
);
  // ============================================================
  // Pointer block decode
  // Returns {hit, pointer index, sub-address} for an address
  function automatic logic [5:0] ptr_dec(input logic [11:0] a);
    logic [5:0] r;
    logic [11:0] base;
    r = 6'h00;
    for (int n = 0; n < dmag_pkg::NUM_PTRS; n++) begin
      base = dmag_pkg::PTR_BLK0 - 12'(n) * dmag_pkg::PTR_BLK_STEP;
      if (a[11:3] == base[11:3]) begin
        r = {1'b1, 2'(n), a[2:0]};
      end
    end
    return r;
  endfunction

  // ============================================================
  // Pointers
  logic [11:0] ptr [dmag_pkg::NUM_PTRS];
  logic [2:0] inc_v;
  logic [2:0] dec_v;
  logic [2:0] wh_v;
  logic [2:0] wl_v;

  // Three independent pointers, each a high:low pair
  for (genvar g = 0; g < dmag_pkg::NUM_PTRS; g++) begin : g_ptr
    dmag_ptr_reg #(.W(dmag_pkg::ADDR_W)) u_ptr (
      .clock(clock),
      .rstn(rstn),
      .inc(inc_v[g]),
      .dec(dec_v[g]),
      .wr_high(wh_v[g]),
      .wr_low(wl_v[g]),
      .wdata(wdata),
      .ptr(ptr[g])
    );
  end

  // ============================================================
  // Address formation and target classification
  logic [3:0] bank_select;
  logic [3:0] next_bank_select;
  logic [11:0] eff;
  logic [11:0] tgt;
  logic [5:0] d1;
  logic [5:0] d2;
  logic indir;
  logic port_tgt;
  logic [1:0] pi;
  logic [7:0] rd_val;
  logic to_ram;
  logic [11:0] next_ram_addr;
  logic next_ram_rd;
  logic next_ram_wr;
  logic next_stage_busy;
  logic next_stage_ram;
  logic next_stage_zero;
  logic next_stage_hold;

  // One pass from operand to target; internal bytes never reach the RAM port
  always_comb begin
    inc_v = 3'h0;
    dec_v = 3'h0;
    wh_v = 3'h0;
    wl_v = 3'h0;
    pi = 2'h0;
    indir = 1'b0;
    rd_val = dmag_pkg::DATA_ZERO;
    to_ram = 1'b0;
    next_bank_select = bank_select;
    if (full_move) begin
      eff = full_addr;
    end else if (access_sel) begin
      eff = {bank_select, file_offset};
    end else if (file_offset < dmag_pkg::ACCESS_SPLIT) begin
      eff = {dmag_pkg::ACCESS_LOW_BANK, file_offset};
    end else begin
      eff = {dmag_pkg::SFR_BANK, file_offset};
    end
    d1 = ptr_dec(eff);
    tgt = eff;
    // A port address is never storage; it redirects through its pointer
    if (d1[5] && d1[2:0] <= dmag_pkg::SUB_PLAIN) begin
      indir = 1'b1;
      pi = d1[4:3];
      case (d1[2:0])
        dmag_pkg::SUB_PRE_INC: begin
          tgt = ptr[pi] + 1'b1;
          inc_v[pi] = req;
        end
        dmag_pkg::SUB_POST_INC: begin
          tgt = ptr[pi];
          inc_v[pi] = req;
        end
        dmag_pkg::SUB_POST_DEC: begin
          tgt = ptr[pi];
          dec_v[pi] = req;
        end
        dmag_pkg::SUB_OFFSET_IDX: begin
          tgt = ptr[pi] + {{4{working_reg[7]}}, working_reg};
        end
        default: begin
          tgt = ptr[pi];
        end
      endcase
    end
    d2 = ptr_dec(tgt);
    port_tgt = indir && d2[5] && d2[2:0] <= dmag_pkg::SUB_PLAIN;
    if (port_tgt) begin
      rd_val = dmag_pkg::DATA_ZERO;
    end else if (tgt == dmag_pkg::BANK_SELECT_ADDR) begin
      rd_val = {dmag_pkg::UPPER_ZERO, bank_select};
      if (req && req_write) begin
        next_bank_select = wdata[3:0];
      end
    end else if (d2[5] && d2[2:0] == dmag_pkg::SUB_HIGH) begin
      rd_val = {dmag_pkg::UPPER_ZERO, ptr[d2[4:3]][11:8]};
      wh_v[d2[4:3]] = req && req_write;
    end else if (d2[5] && d2[2:0] == dmag_pkg::SUB_LOW) begin
      rd_val = ptr[d2[4:3]][7:0];
      wl_v[d2[4:3]] = req && req_write;
    end else if (int'(tgt[11:8]) >= BANKS_IMPL && tgt[11:8] != dmag_pkg::SFR_BANK) begin
      rd_val = dmag_pkg::DATA_ZERO;
    end else begin
      to_ram = 1'b1;
    end
    if (bank_literal_load) begin
      next_bank_select = bank_literal[3:0];
    end
    next_ram_addr = to_ram ? tgt : ram_addr;
    next_ram_rd = req && !req_write && to_ram;
    next_ram_wr = req && req_write && to_ram;
    next_stage_busy = req;
    next_stage_ram = req && !req_write && to_ram;
    next_stage_zero = req && !req_write && port_tgt;
    next_stage_hold = req && req_write && port_tgt;
  end

  // ============================================================
  // Pipeline: RAM strobes one cycle after the request, answer one later
  logic stage_busy;
  logic stage_ram;
  logic stage_zero;
  logic stage_hold;
  logic [7:0] stage_val;

  // RAM is read asynchronously, so its data is caught in the answer stage
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      bank_select <= dmag_pkg::BANK_SELECT_RST;
      ram_addr <= dmag_pkg::PTR_RST;
      ram_rd <= 1'b0;
      ram_wr <= 1'b0;
      ram_wdata <= dmag_pkg::DATA_ZERO;
      stage_busy <= 1'b0;
      stage_ram <= 1'b0;
      stage_zero <= 1'b0;
      stage_hold <= 1'b0;
      stage_val <= dmag_pkg::DATA_ZERO;
      done <= 1'b0;
      rd_data <= dmag_pkg::DATA_ZERO;
      zero_force <= 1'b0;
      flags_hold <= 1'b0;
    end else begin
      bank_select <= next_bank_select;
      ram_addr <= next_ram_addr;
      ram_rd <= next_ram_rd;
      ram_wr <= next_ram_wr;
      ram_wdata <= wdata;
      stage_busy <= next_stage_busy;
      stage_ram <= next_stage_ram;
      stage_zero <= next_stage_zero;
      stage_hold <= next_stage_hold;
      stage_val <= rd_val;
      done <= stage_busy;
      rd_data <= stage_ram ? ram_rdata : stage_val;
      zero_force <= stage_zero;
      flags_hold <= stage_hold;
    end
  end

  // ============================================================
  // Checks
  localparam logic [11:0] PLAIN0 = dmag_pkg::PTR_BLK0 + 12'(dmag_pkg::SUB_PLAIN);
  localparam logic [11:0] POSTINC0 = dmag_pkg::PTR_BLK0 + 12'(dmag_pkg::SUB_POST_INC);

  access_low_a: assert property (@(posedge clock) disable iff (!rstn)
    req && req_write && !full_move && !access_sel && file_offset < 8'h80
    |=> ram_wr && ram_addr == {4'h0, $past(file_offset)})
    else $error("low access half mapped wrongly");

  access_high_a: assert property (@(posedge clock) disable iff (!rstn)
    req && req_write && !full_move && !access_sel && file_offset >= 8'h80
    && file_offset < 8'hD0
    |=> ram_wr && ram_addr == {4'hF, $past(file_offset)})
    else $error("high access half mapped wrongly");

  bank_map_a: assert property (@(posedge clock) disable iff (!rstn)
    req && !req_write && !full_move && access_sel && bank_select != 4'hF
    && int'(bank_select) < BANKS_IMPL |=> ram_rd && ram_addr == {$past(bank_select),
    $past(file_offset)})
    else $error("banked address wrong");

  full_move_a: assert property (@(posedge clock) disable iff (!rstn)
    req && full_move && full_addr[11:8] == 4'h1 |=> (ram_rd || ram_wr)
    && ram_addr == $past(full_addr))
    else $error("full address move not taken whole");

  bank_load_a: assert property (@(posedge clock) disable iff (!rstn)
    bank_literal_load |=> bank_select == $past(bank_literal[3:0]))
    else $error("bank literal load lost");

  unimpl_zero_a: assert property (@(posedge clock) disable iff (!rstn)
    req && !req_write && !full_move && access_sel && bank_select != 4'hF
    && int'(bank_select) >= BANKS_IMPL |=> !ram_rd ##1 done && rd_data == 8'h00 && !zero_force)
    else $error("unimplemented bank access reached RAM");

  post_inc_a: assert property (@(posedge clock) disable iff (!rstn)
    req && !req_write && full_move && full_addr == POSTINC0
    |=> ram_rd && ram_addr == $past(ptr[0]) && ptr[0] == $past(ptr[0]) + 1'b1)
    else $error("post-increment port misbehaved");

  port_read_a: assert property (@(posedge clock) disable iff (!rstn)
    req && !req_write && full_move && full_addr == PLAIN0 && ptr[0] == PLAIN0
    |-> ##2 done && zero_force && rd_data == 8'h00)
    else $error("port read through pointer not zero");

  port_write_a: assert property (@(posedge clock) disable iff (!rstn)
    req && req_write && full_move && full_addr == PLAIN0 && ptr[0] == PLAIN0
    |=> !ram_wr ##1 done && flags_hold && !zero_force)
    else $error("port write through pointer not a no-op");
endmodule

// File: verification/dmag_ram_model.sv
`timescale 1ns/1ps
// ============================================================
// Data RAM behind the generator: combinational read, write on the strobe
module dmag_ram_model (
  // Clock
  input wire logic clock,
  // RAM side of the generator
  input wire logic [11:0] ram_addr,
  input wire logic ram_rd,
  input wire logic ram_wr,
  input wire logic [7:0] ram_wdata,
  output logic [7:0] ram_rdata
);
  // Whole space as sixteen banks of 256 static bytes
  logic [7:0] mem [4096];
  logic [7:0] last = 8'h00;
  // Outside a read the bus shows the inverse of the last value, so a late sample fails
  always_comb begin
    ram_rdata = ram_rd ? mem[ram_addr] : ~last;
  end
  // Writes land on the edge that closes the strobe cycle
  always @(posedge clock) begin
    if (ram_wr) mem[ram_addr] <= ram_wdata;
    if (ram_rd) last <= mem[ram_addr];
  end
endmodule

// File: verification/test_data_memory_address_generator.sv
`timescale 1ns/1ps
// ============================================================
// Self-checking bench of the data memory address generator
module test_data_memory_address_generator;
  localparam int BANKS = 6;
  logic clock, rstn, req, req_write, access_sel, full_move, bank_literal_load;
  logic [7:0] file_offset, wdata, working_reg, bank_literal, ram_rdata, ram_wdata, rd_data;
  logic [11:0] full_addr, ram_addr;
  logic ram_rd, ram_wr, done, zero_force, flags_hold;
  int fail_count = 0;
  int cmp_count = 0;
  logic [7:0] shadow [4096];
  logic [11:0] ptr [3];
  logic [3:0] bank;
  logic [20:0] aq [$];
  logic [10:0] rq [$];
  logic [20:0] ae;
  logic [10:0] re;

  dmag_core #(.BANKS_IMPL(BANKS)) u_dmag_core (.clock(clock), .rstn(rstn), .req(req),
    .req_write(req_write), .file_offset(file_offset), .access_sel(access_sel),
    .full_move(full_move), .full_addr(full_addr), .wdata(wdata), .working_reg(working_reg),
    .bank_literal_load(bank_literal_load), .bank_literal(bank_literal),
    .ram_rdata(ram_rdata), .ram_addr(ram_addr), .ram_rd(ram_rd), .ram_wr(ram_wr),
    .ram_wdata(ram_wdata), .done(done), .rd_data(rd_data), .zero_force(zero_force),
    .flags_hold(flags_hold));
  dmag_ram_model u_dmag_ram_model (.clock(clock), .ram_addr(ram_addr), .ram_rd(ram_rd),
    .ram_wr(ram_wr), .ram_wdata(ram_wdata), .ram_rdata(ram_rdata));

  // 10 MHz clock
  initial begin
    clock = 0;
    forever #50 clock = ~clock;
  end

  task automatic err(input string m);
    fail_count++;
    $display("ERROR %0t %s", $time, m);
  endtask

  task automatic finish_test();
    if (fail_count == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  function automatic logic [11:0] base(input int i);
    base = dmag_pkg::PTR_BLK0 - dmag_pkg::PTR_BLK_STEP * 12'(i);
  endfunction

  // Pointer whose five ports hold this address, or -1
  function automatic int port_of(input logic [11:0] x);
    port_of = -1;
    for (int i = 0; i < 3; i++) begin
      if ((x & 12'hFF8) == base(i) && x[2:0] <= dmag_pkg::SUB_PLAIN) port_of = i;
    end
  endfunction

  // One request; the expected answer and RAM access are noted as it is issued
  task automatic acc(input logic w, fm, sel, input logic [11:0] a, input logic [7:0] d, wr_reg);
    logic [11:0] e;
    logic [11:0] t;
    logic [7:0] rd;
    logic zf;
    logic fh;
    logic h;
    int n;
    logic [11:0] po [3];
    @(posedge clock);
    #1;
    req = 1;
    req_write = w;
    full_move = fm;
    access_sel = sel;
    full_addr = a;
    file_offset = a[7:0];
    wdata = d;
    working_reg = wr_reg;
    e = fm ? a : (sel ? {bank, a[7:0]} : {{4{a[7]}}, a[7:0]});
    zf = 0;
    fh = 0;
    h = 0;
    rd = 8'h00;
    t = e;
    po = ptr;
    n = port_of(e);
    if (n >= 0) begin
      t = ptr[n];
      case (e[2:0])
        dmag_pkg::SUB_OFFSET_IDX: t = ptr[n] + {{4{wr_reg[7]}}, wr_reg};
        dmag_pkg::SUB_PRE_INC: begin
          ptr[n] = ptr[n] + 12'h001;
          t = ptr[n];
        end
        dmag_pkg::SUB_POST_DEC: ptr[n] = ptr[n] - 12'h001;
        dmag_pkg::SUB_POST_INC: ptr[n] = ptr[n] + 12'h001;
        default: ;
      endcase
    end
    // A byte write cancels that pointer's step; reads show the value before the step
    for (int i = 0; i < 3; i++) begin
      if (t == base(i) + 12'(dmag_pkg::SUB_HIGH)) begin
        rd = {4'h0, po[i][11:8]};
        if (w) begin
          ptr[i] = po[i];
          ptr[i][11:8] = d[3:0];
        end
        h = 1;
      end
      if (t == base(i) + 12'(dmag_pkg::SUB_LOW)) begin
        rd = po[i][7:0];
        if (w) begin
          ptr[i] = po[i];
          ptr[i][7:0] = d;
        end
        h = 1;
      end
    end
    if (n >= 0 && port_of(t) >= 0) begin
      zf = !w;
      fh = w;
    end else if (t == dmag_pkg::BANK_SELECT_ADDR) begin
      rd = {4'h0, bank};
      if (w) bank = d[3:0];
    end else if (!h && (t[11:8] < BANKS || t[11:8] == dmag_pkg::SFR_BANK)) begin
      rd = shadow[t];
      aq.push_back({w, t, d});
      if (w) shadow[t] = d;
    end
    rq.push_back({w, zf, fh, rd});
  endtask

  task automatic bl(input logic [7:0] lit);
    @(posedge clock);
    #1;
    req = 0;
    bank_literal_load = 1;
    bank_literal = lit;
    bank = lit[3:0];
    @(posedge clock);
    #1;
    bank_literal_load = 0;
  endtask

  task automatic set_ptr(input int n, input logic [11:0] p);
    acc(1, 1, 0, base(n) + 12'h005, {4'($urandom), p[11:8]}, 8'h00);
    acc(1, 1, 0, base(n) + 12'h006, p[7:0], 8'h00);
  endtask

  // Watcher: each strobe or answer is matched with the oldest note
  always @(negedge clock) begin
    if (ram_rd === 1'b1 || ram_wr === 1'b1) begin
      if (aq.size() == 0) err("ram strobe with no request");
      else begin
        ae = aq.pop_front();
        cmp_count++;
        if (ram_wr !== ae[20] || ram_rd !== !ae[20] || ram_addr !== ae[19:8] ||
            (ae[20] && ram_wdata !== ae[7:0])) err("ram access differs");
      end
    end
    if (done === 1'b1) begin
      if (rq.size() == 0) err("answer with no request");
      else begin
        re = rq.pop_front();
        cmp_count++;
        if (zero_force !== re[9] || flags_hold !== re[8] || (!re[10] && rd_data !== re[7:0]))
          err("answer differs");
      end
    end
  end

  // A hang ends the run as a mismatch
  initial begin
    repeat (50000) @(posedge clock);
    err("run did not end");
    finish_test();
  end

  initial begin
    logic [7:0] o;
    logic [11:0] p;
    rstn = 0;
    req = 0;
    req_write = 0;
    access_sel = 0;
    full_move = 0;
    bank_literal_load = 0;
    file_offset = 8'h00;
    wdata = 8'h00;
    working_reg = 8'h00;
    bank_literal = 8'h00;
    full_addr = 12'h000;
    bank = dmag_pkg::BANK_SELECT_RST;
    void'($urandom(1));
    for (int i = 0; i < 4096; i++) begin
      shadow[i] = 8'($urandom);
      u_dmag_ram_model.mem[i] = shadow[i];
    end
    for (int i = 0; i < 3; i++) ptr[i] = dmag_pkg::PTR_RST;
    repeat (6) @(posedge clock);
    #1;
    rstn = 1;
    cmp_count++;
    if (done !== 1'b0 || ram_rd !== 1'b0 || ram_wr !== 1'b0 || rd_data !== 8'h00)
      err("outputs not cleared by reset");
    acc(0, 0, 0, 12'h0D0, 8'h00, 8'h00);
    acc(0, 1, 0, 12'hFEE, 8'h00, 8'h00);
    // Fast access region, both edges of the split, write then read back to back
    for (int i = 0; i < 16; i++) begin
      o = (i < 2) ? 8'h7F + 8'(i) : ((i & 1) ? 8'h80 + 8'($urandom_range(79)) : 8'($urandom));
      o[7] = (i > 1) ? i[0] : o[7];
      acc(1, 0, 0, {4'h0, o}, 8'($urandom), 8'h00);
      acc(0, 0, 0, {4'h0, o}, 8'h00, 8'h00);
    end
    // Every bank, implemented or not, then a full move that ignores the bank
    for (int b = 0; b < 16; b++) begin
      o = (b == 0) ? 8'hFF : 8'($urandom);
      bl({4'($urandom), 4'(b)});
      acc(1, 0, 1, {4'h0, o}, 8'($urandom), 8'h00);
      acc(0, 0, 1, {4'h0, o}, 8'h00, 8'h00);
      acc(0, 1, 1, {4'(b % 6), o}, 8'h00, 8'h00);
    end
    // Bank select upper half reads zero and ignores writes
    acc(1, 0, 0, 12'h0D0, 8'hA2, 8'h00);
    acc(0, 0, 0, 12'h0D0, 8'h00, 8'h00);
    acc(1, 0, 1, 12'h033, 8'($urandom), 8'h00);
    acc(0, 0, 1, 12'h033, 8'h00, 8'h00);
    // Every port of every pointer, with carry and borrow across the byte split
    for (int n = 0; n < 3; n++) begin
      for (int s = 0; s < 5; s++) begin
        p = (s == 3) ? 12'h0FF : ((s == 2) ? 12'h100 : 12'h100 + 12'($urandom_range(1151)));
        set_ptr(n, p);
        acc(1'(n & 1), 1, 0, base(n) + 12'(s), 8'($urandom), 8'($urandom));
        acc(0, 1, 0, base(n) + 12'h005, 8'h00, 8'h00);
        acc(0, 1, 0, base(n) + 12'h006, 8'h00, 8'h00);
      end
    end
    // Pointer aimed at a port: read gives zero flag, write holds flags
    set_ptr(1, 12'hFEC);
    acc(0, 1, 0, base(1) + 12'h004, 8'h00, 8'h00);
    acc(1, 1, 0, base(1) + 12'h003, 8'($urandom), 8'h00);
    acc(0, 1, 0, base(1) + 12'h006, 8'h00, 8'h00);
    set_ptr(0, 12'hFEC);
    acc(0, 1, 0, 12'hFEC, 8'h00, 8'h00);
    acc(1, 1, 0, 12'hFEC, 8'($urandom), 8'h00);
    // Pointer aimed at its own low byte: the write beats the step
    set_ptr(0, 12'hFEE);
    acc(1, 1, 0, 12'hFEB, 8'h40, 8'h00);
    acc(0, 1, 0, 12'hFEE, 8'h00, 8'h00);
    acc(0, 1, 0, 12'hFED, 8'h00, 8'h00);
    repeat (4) begin
      @(posedge clock);
      #1;
      req = 0;
    end
    if (aq.size() != 0 || rq.size() != 0) err("expected results never appeared");
    finish_test();
  end
endmodule
